// File: include/caf_map.svh
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH

// register word addresses on the plain register port
`define CAF_OFF_CTRL2      6'h00
`define CAF_OFF_MODE       6'h01
`define CAF_OFF_SEL_LO     6'h02
`define CAF_OFF_SEL_HI     6'h03
`define CAF_OFF_MASK0      6'h04
`define CAF_OFF_MASK1      6'h05
`define CAF_OFF_MASK2      6'h06
`define CAF_OFF_MASK_HI    6'h07
`define CAF_OFF_ENABLE     6'h08
`define CAF_OFF_STATUS     6'h09
`define CAF_OFF_PAT_LO     6'h10
`define CAF_OFF_PAT_HI     6'h20

// field positions
`define CAF_COUNT_MSB      4
`define CAF_MODE_CFG_BIT   0
`define CAF_STAT_HIT_BIT   4
`define CAF_STAT_IDX_MSB   3

// reset values
`define CAF_RST_CTRL2      16'h0000
`define CAF_RST_MODE_CFG   1'h1
`define CAF_RST_SEL        16'h0000
`define CAF_RST_MASK       16'h0000
`define CAF_RST_ENABLE     16'h0000
`define CAF_RST_MASK_HI    6'h00

// compare count encodings
`define CAF_COUNT_NONE     5'h00
`define CAF_COUNT_FIRST    5'h01
`define CAF_COUNT_LAST     5'h11

`endif

// File: include/caf_pkg.sv
package caf_pkg;

	typedef logic [15:0] caf_word_t;
	typedef logic [5:0]  caf_addr_t;
	typedef logic [17:0] caf_eid_t;
	typedef logic [4:0]  caf_count_t;

	// mask source field encodings
	typedef enum logic [1:0] {
		CAF_MSK0  = 2'h0,
		CAF_MSK1  = 2'h1,
		CAF_MSK2  = 2'h2,
		CAF_NOMSK = 2'h3
	} caf_msk_src_t;

endpackage

// File: include/caf_flt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface caf_flt_if #(
	parameter int NUM_FILTERS = 16
);
	import caf_pkg::*;
	localparam int IW = $clog2(NUM_FILTERS);

	logic [NUM_FILTERS-1:0][17:0] pattern;
	logic [NUM_FILTERS-1:0][1:0]  mask_src;
	logic [2:0][17:0]             masks;
	logic [NUM_FILTERS-1:0]       enable;
	caf_count_t                   count;
	logic                         msg_ide;
	caf_eid_t                     msg_eid;
	logic [23:0]                  msg_data;
	logic                         hit;
	logic [IW-1:0]                hit_index;

	modport cfg (
		output pattern, mask_src, masks, enable, count, msg_ide, msg_eid, msg_data,
		input  hit, hit_index
	);
	modport flt (
		input  pattern, mask_src, masks, enable, count, msg_ide, msg_eid, msg_data,
		output hit, hit_index
	);
endinterface

`default_nettype wire

// File: logic/caf_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "caf_map.svh"

module caf_match #(
	parameter int NUM_FILTERS = 16
) (
	caf_flt_if.flt flt
);
	import caf_pkg::*;
	localparam int IW = $clog2(NUM_FILTERS);

	// selected mask, all ones when the filter uses none
	function automatic caf_eid_t pick_mask(input logic [1:0] src, input logic [2:0][17:0] m);
		case (caf_msk_src_t'(src))
			CAF_MSK0: pick_mask = m[0];
			CAF_MSK1: pick_mask = m[1];
			CAF_MSK2: pick_mask = m[2];
			CAF_NOMSK: pick_mask = '1;
			default: pick_mask = '1;
		endcase
	endfunction

	// number of leading data bits compared; invalid encodings compare none
	function automatic logic [4:0] data_span(input caf_count_t c);
		if (c == `CAF_COUNT_NONE || c > `CAF_COUNT_LAST) begin
			data_span = 5'h00;
		end else if (c == `CAF_COUNT_FIRST) begin
			data_span = 5'h01;
		end else begin
			data_span = c + 5'h01;
		end
	endfunction

	caf_eid_t   cand;
	caf_eid_t   care;
	logic [4:0] span;

	// standard frames offer data bits, msb of data byte 1 first, in place of the id
	always_comb begin
		span = data_span(flt.count);
		for (int k = 0; k < 18; k++) begin
			cand[k] = flt.msg_ide ? flt.msg_eid[k] : flt.msg_data[23-k];
			care[k] = flt.msg_ide ? 1'b1 : (k < int'(span));
		end
	end

	// scan high to low so that the lowest matching filter wins
	always_comb begin
		flt.hit = 1'b0;
		flt.hit_index = '0;
		for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
			if (flt.enable[i] &&
			    ((cand ^ flt.pattern[i]) & care & pick_mask(flt.mask_src[i], flt.masks)) == '0) begin
				flt.hit = 1'b1;
				flt.hit_index = IW'(i);
			end
		end
	end

endmodule // caf_match

`default_nettype wire

// File: logic/caf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "caf_map.svh"


module caf_top #(
	parameter int NUM_FILTERS = 16
) (
	input  wire logic               clock,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire caf_pkg::caf_addr_t addr,
	input  wire caf_pkg::caf_word_t wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	input  wire caf_pkg::caf_count_t compare_count_in,
	input  wire logic               msg_valid,
	input  wire logic               msg_ide,
	input  wire caf_pkg::caf_eid_t  msg_eid,
	input  wire logic [23:0]        msg_data,
	output var  caf_pkg::caf_word_t rdata,
	output var  logic               accept,
	output var  logic [3:0]         accept_filter,
	output var  logic               config_mode
);
	import caf_pkg::*;

	if (NUM_FILTERS < 2 || NUM_FILTERS > 16) begin : g_bad_filters
		$error("caf_top: NUM_FILTERS must lie in 2..16");
	end

	function automatic logic is_pat_lo(input caf_addr_t a);
		is_pat_lo = (a[5:4] == 2'(`CAF_OFF_PAT_LO >> 4)) && (int'(a[3:0]) < NUM_FILTERS);
	endfunction

	function automatic logic is_pat_hi(input caf_addr_t a);
		is_pat_hi = (a[5:4] == 2'(`CAF_OFF_PAT_HI >> 4)) && (int'(a[3:0]) < NUM_FILTERS);
	endfunction

	// configuration state
	logic                         cfg_q;
	caf_count_t                   count_q;
	logic [31:0]                  sel_q;
	logic [2:0][15:0]             mask_q;
	logic [5:0]                   mask_hi_q;
	logic [NUM_FILTERS-1:0]       enable_q;
	logic                         next_cfg;
	caf_count_t                   next_count;
	logic [31:0]                  next_sel;
	logic [2:0][15:0]             next_mask;
	logic [5:0]                   next_mask_hi;
	logic [NUM_FILTERS-1:0]       next_enable;
	logic [NUM_FILTERS-1:0][17:0] pattern_q;
	logic [NUM_FILTERS-1:0][17:0] next_pattern;
	logic                         hit_seen_q;
	logic                         next_hit_seen;
	logic [3:0]                   next_filter;
	logic                         next_accept;
	caf_word_t                    next_rdata;
	logic [17:0]                  addr_pattern;

	// config writes; the mode register itself stays writable so software can leave
	always_comb begin
		next_cfg = cfg_q;
		next_count = count_q;
		next_sel = sel_q;
		next_mask = mask_q;
		next_mask_hi = mask_hi_q;
		next_enable = enable_q;
		if (cfg_q) begin
			next_count = compare_count_in; // read-only to software, loaded while configuring
		end
		if (wr && addr == `CAF_OFF_MODE) begin
			next_cfg = wdata[`CAF_MODE_CFG_BIT];
		end
		if (wr && cfg_q) begin
			case (addr)
				`CAF_OFF_SEL_LO: next_sel[15:0] = wdata;
				`CAF_OFF_SEL_HI: next_sel[31:16] = wdata;
				`CAF_OFF_MASK0: next_mask[0] = wdata;
				`CAF_OFF_MASK1: next_mask[1] = wdata;
				`CAF_OFF_MASK2: next_mask[2] = wdata;
				`CAF_OFF_MASK_HI: next_mask_hi = wdata[5:0];
				`CAF_OFF_ENABLE: next_enable = wdata[NUM_FILTERS-1:0];
				default: ; // control two ignores writes
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_q <= `CAF_RST_MODE_CFG;
			count_q <= caf_count_t'(`CAF_RST_CTRL2);
			sel_q <= {`CAF_RST_SEL, `CAF_RST_SEL};
			mask_q <= {3{`CAF_RST_MASK}};
			mask_hi_q <= `CAF_RST_MASK_HI;
			enable_q <= NUM_FILTERS'(`CAF_RST_ENABLE);
		end else if (ce) begin
			cfg_q <= next_cfg;
			count_q <= next_count;
			sel_q <= next_sel;
			mask_q <= next_mask;
			mask_hi_q <= next_mask_hi;
			enable_q <= next_enable;
		end
	end

	// pattern store: no reset, software must load it before going on-line
	always_comb begin
		next_pattern = pattern_q;
		if (wr && cfg_q && is_pat_lo(addr)) begin
			next_pattern[addr[3:0]][15:0] = wdata;
		end
		if (wr && cfg_q && is_pat_hi(addr)) begin
			next_pattern[addr[3:0]][17:16] = wdata[1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (ce) begin
			pattern_q <= next_pattern;
		end
	end

	// matcher sees live message fields; its verdict is registered below
	caf_flt_if #(.NUM_FILTERS(NUM_FILTERS)) flt ();

	assign flt.pattern = pattern_q;
	assign flt.mask_src = sel_q[2*NUM_FILTERS-1:0];
	// one assignment for all three masks keeps the variable to a single driver
	assign flt.masks = {
		{mask_hi_q[5:4], mask_q[2]},
		{mask_hi_q[3:2], mask_q[1]},
		{mask_hi_q[1:0], mask_q[0]}
	};
	assign flt.enable = enable_q;
	assign flt.count = count_q;
	assign flt.msg_ide = msg_ide;
	assign flt.msg_eid = msg_eid;
	assign flt.msg_data = msg_data;

	caf_match #(.NUM_FILTERS(NUM_FILTERS)) u_match (
		.flt (flt.flt)
	);

	// frames are not judged in configuration mode, the receiver is off then
	always_comb begin
		next_accept = msg_valid && !cfg_q && flt.hit;
		next_filter = accept_filter;
		next_hit_seen = hit_seen_q;
		if (next_accept) begin
			next_filter = 4'(flt.hit_index);
			next_hit_seen = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			accept <= 1'b0;
			accept_filter <= 4'h0;
			hit_seen_q <= 1'b0;
		end else if (ce) begin
			accept <= next_accept;
			accept_filter <= next_filter;
			hit_seen_q <= next_hit_seen;
		end
	end

	assign addr_pattern = pattern_q[addr[3:0]];

	// read mux; unmapped words read zero
	always_comb begin
		next_rdata = 16'h0000;
		if (rd) begin
			case (addr)
				`CAF_OFF_CTRL2: next_rdata = {11'h000, count_q};
				`CAF_OFF_MODE: next_rdata = {15'h0000, cfg_q};
				`CAF_OFF_SEL_LO: next_rdata = sel_q[15:0];
				`CAF_OFF_SEL_HI: next_rdata = sel_q[31:16];
				`CAF_OFF_MASK0: next_rdata = mask_q[0];
				`CAF_OFF_MASK1: next_rdata = mask_q[1];
				`CAF_OFF_MASK2: next_rdata = mask_q[2];
				`CAF_OFF_MASK_HI: next_rdata = {10'h000, mask_hi_q};
				`CAF_OFF_ENABLE: next_rdata = 16'(enable_q);
				`CAF_OFF_STATUS: next_rdata = {11'h000, hit_seen_q, accept_filter};
				default: begin
					if (is_pat_lo(addr)) begin
						next_rdata = addr_pattern[15:0];
					end else if (is_pat_hi(addr)) begin
						next_rdata = {14'h0000, addr_pattern[17:16]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata <= 16'h0000;
			config_mode <= `CAF_RST_MODE_CFG;
		end else if (ce) begin
			rdata <= next_rdata;
			config_mode <= next_cfg;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_frame_hit;
		ce && msg_valid && !cfg_q && flt.hit;
	endsequence

	sequence s_accept_out;
		accept && accept_filter == 4'($past(flt.hit_index));
	endsequence

	// filter 0 alone, unmasked, extended frame
	sequence s_solo_ext;
		ce && msg_valid && msg_ide && !cfg_q && enable_q == NUM_FILTERS'(1) &&
		sel_q[1:0] == CAF_NOMSK;
	endsequence

	// filter 0 alone, unmasked, standard frame
	sequence s_solo_std;
		ce && msg_valid && !msg_ide && !cfg_q && enable_q == NUM_FILTERS'(1) &&
		sel_q[1:0] == CAF_NOMSK;
	endsequence

	chk_ctrl2_upper_zero: assert property (
		ce && rd && addr == `CAF_OFF_CTRL2 |=> rdata[15:5] == 11'h000 && rdata[4:0] == $past(count_q))
		else $error("control two read shows nonzero upper bits or wrong count");

	// frozen cycles are kept out of most antecedents by requiring ce
	chk_count_load: assert property (
		ce && cfg_q ##1 (ce && !cfg_q) [*2] |-> count_q == $past(count_q))
		else $error("compare count changed while on-line");

	chk_pattern_locked: assert property (
		ce && !cfg_q && wr && is_pat_lo(addr) |=> pattern_q[$past(addr[3:0])] == $past(addr_pattern))
		else $error("pattern changed while on-line");

	chk_sel_locked: assert property (
		ce && !cfg_q && wr |=> $stable(sel_q) && $stable(mask_q) && $stable(enable_q))
		else $error("filter configuration changed while on-line");

	chk_sel_readback: assert property (
		ce && cfg_q && wr && addr == `CAF_OFF_SEL_LO ##1 ce && rd && addr == `CAF_OFF_SEL_LO
		|=> rdata == $past(wdata, 2))
		else $error("selection register did not read back its write");

	chk_accept_timing: assert property (
		s_frame_hit |=> s_accept_out)
		else $error("accept missing or wrong filter one cycle after a hit");

	chk_accept_cause: assert property (
		$rose(accept) |-> $past(msg_valid) && !$past(cfg_q))
		else $error("accept raised without an on-line frame");

	chk_exact_match: assert property (
		(s_solo_ext and msg_eid == pattern_q[0]) |=> accept && accept_filter == 4'h0)
		else $error("exact identifier match was not accepted");

	chk_bit_mismatch: assert property (
		(s_solo_ext and msg_eid != pattern_q[0]) |=> !accept)
		else $error("mismatched identifier was accepted");

	chk_mask_source: assert property (
		ce && msg_valid && msg_ide && !cfg_q && enable_q == NUM_FILTERS'(1) &&
		sel_q[1:0] == CAF_MSK2 && ((msg_eid ^ pattern_q[0]) & flt.masks[2]) == 18'h0_0000
		|=> accept)
		else $error("filter 0 on mask 2 refused a frame that differs only outside the mask");

	chk_first_data_bit: assert property (
		(s_solo_std and count_q == `CAF_COUNT_FIRST && msg_data[23] != pattern_q[0][0]) |=> !accept)
		else $error("count one ignored data byte 1 bit 7");

	chk_last_data_bit: assert property (
		(s_solo_std and count_q == `CAF_COUNT_LAST && msg_data[6] != pattern_q[0][17]) |=> !accept)
		else $error("count seventeen ignored data byte 3 bit 6");

	chk_ce_freeze: assert property (
		!ce |=> $stable(cfg_q) && $stable(sel_q) && $stable(count_q) &&
		$stable(accept) && $stable(rdata))
		else $error("state moved while the clock enable was low");

	chk_config_no_accept: assert property (
		ce && cfg_q |=> !accept)
		else $error("frame accepted in configuration mode");

endmodule // caf_top

`default_nettype wire

// File: bench/caf_node_model.sv
`timescale 1ns/1ps
`default_nettype none

module caf_node_model (
	input  wire logic              clock,
	output var  logic              msg_valid,
	output var  logic              msg_ide,
	output var  caf_pkg::caf_eid_t msg_eid,
	output var  logic [23:0]       msg_data
);
	import caf_pkg::*;

	// bus idle at start
	initial begin
		msg_valid = 1'b0;
		msg_ide   = 1'b0;
		msg_eid   = '0;
		msg_data  = '0;
	end

	// one frame per call; lines are inverted afterwards so a stale frame never passes
	task automatic send(input logic ide, input caf_eid_t eid, input logic [23:0] data);
		@(posedge clock);
		msg_valid <= 1'b1;
		msg_ide   <= ide;
		msg_eid   <= eid;
		msg_data  <= data;
		@(posedge clock);
		msg_valid <= 1'b0;
		msg_ide   <= ~ide;
		msg_eid   <= ~eid;
		msg_data  <= ~data;
	endtask
endmodule // caf_node_model

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "caf_map.svh"

module tb;
	import caf_pkg::*;
	logic        clock, srst, ce, wr, rd;
	logic        msg_valid, msg_ide, accept, config_mode;
	caf_addr_t   addr;
	caf_word_t   wdata, rdata, sel;
	caf_count_t  count_in, c;
	caf_eid_t    msg_eid, pat;
	logic [23:0] msg_data, data;
	logic [3:0]  accept_filter;
	int          fail_count, compares, fi, j, seed;

	caf_top dut_u (.clock(clock), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .compare_count_in(count_in), .msg_valid(msg_valid), .msg_ide(msg_ide),
		.msg_eid(msg_eid), .msg_data(msg_data), .rdata(rdata), .accept(accept),
		.accept_filter(accept_filter), .config_mode(config_mode));
	caf_node_model node_u (.clock(clock), .msg_valid(msg_valid), .msg_ide(msg_ide),
		.msg_eid(msg_eid), .msg_data(msg_data));

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// strobes last one edge; the leading wait keeps two calls from touching wr in one step
	task automatic reg_wr(input caf_addr_t a, input caf_word_t d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe is taken
	task automatic rd_chk(input caf_addr_t a, input caf_word_t exp);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask

	// write then read back with no idle cycle between the two strobes
	task automatic wr_rd_chk(input caf_addr_t a, input caf_word_t d, input caf_word_t exp);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask

	// data bit k sits at msg_data[23-k] and faces pattern bit k
	function automatic logic data_hit(input caf_count_t n, input caf_eid_t p, input logic [23:0] d);
		int bits;
		bits = (n == 5'h00) ? 0 : (n == 5'h01) ? 1 : int'(n) + 1;
		data_hit = 1'b1;
		for (int k = 0; k < bits; k++) if (d[23-k] !== p[k]) data_hit = 1'b0;
	endfunction

	// mask m leaves id bit m out of the compare; source three compares everything
	function automatic logic id_hit(input int s, input int b);
		return (s != 3) && (b == s);
	endfunction

	task automatic report_and_stop();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// a full run is about 620 cycles; this cuts a hang short
	initial begin
		#1_000_000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		count_in = '0;
		fail_count = 0;
		compares = 0;
		seed = $urandom(1512);
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1 check(config_mode, 1'b1);
		rd_chk(`CAF_OFF_CTRL2, 16'h0000);
		rd_chk(`CAF_OFF_SEL_LO, 16'h0000);
		reg_wr(`CAF_OFF_MASK0, 16'hfffe);
		reg_wr(`CAF_OFF_MASK1, 16'hfffd);
		reg_wr(`CAF_OFF_MASK2, 16'hfffb);
		reg_wr(`CAF_OFF_MASK_HI, 16'h003f);
		// a write while the clock enable is low must leave mask 0 alone
		ce <= 1'b0;
		reg_wr(`CAF_OFF_MASK0, 16'h1234);
		ce <= 1'b1;
		rd_chk(`CAF_OFF_MASK0, 16'hfffe);
		reg_wr(`CAF_OFF_CTRL2, 16'hffff);
		rd_chk(`CAF_OFF_CTRL2, 16'h0000);
		// count readback, kept inside the valid range
		for (int i = 0; i < 3; i++) begin
			c = 5'($urandom % 18);
			count_in <= c;
			reg_wr(`CAF_OFF_MODE, 16'h0001);
			rd_chk(`CAF_OFF_CTRL2, {11'h000, c});
		end
		count_in <= 5'h00;
		// every mask source against a one-bit id difference, filter placed at random except filter 0 when the flipped bit number equals the source number
		for (int s = 0; s < 4; s++) begin
			for (int b = 0; b < 4; b++) begin
				fi = (b == s) ? 0 : $urandom % 8;
				pat = 18'($urandom);
				sel = 16'(s) << (2 * fi);
				reg_wr(`CAF_OFF_MODE, 16'h0001);
				wr_rd_chk(`CAF_OFF_SEL_LO, sel, sel);
				reg_wr(`CAF_OFF_ENABLE, 16'h0001 << fi);
				reg_wr(6'(`CAF_OFF_PAT_LO + fi), pat[15:0]);
				reg_wr(6'(`CAF_OFF_PAT_HI + fi), {14'h0000, pat[17:16]});
				rd_chk(6'(`CAF_OFF_PAT_LO + fi), pat[15:0]);
				reg_wr(`CAF_OFF_MODE, 16'h0000);
				reg_wr(`CAF_OFF_SEL_LO, ~sel);
				reg_wr(6'(`CAF_OFF_PAT_LO + fi), ~pat[15:0]);
				rd_chk(`CAF_OFF_SEL_LO, sel);
				check(config_mode, 1'b0);
				node_u.send(1'b1, pat, 24'($urandom));
				#1 check(accept, 1'b1);
				check(accept_filter, 4'(fi));
				node_u.send(1'b1, pat ^ (18'h0_0001 << b), 24'($urandom));
				#1 check(accept, id_hit(s, b));
			end
		end
		// the last extended pass leaves filter 0 as the last filter to accept
		rd_chk(`CAF_OFF_STATUS, 16'h0010);
		// standard frames: data bits against the pattern for edge and random counts
		reg_wr(`CAF_OFF_MODE, 16'h0001);
		reg_wr(`CAF_OFF_SEL_LO, 16'h0003);
		reg_wr(`CAF_OFF_ENABLE, 16'h0001);
		for (int i = 0; i < 16; i++) begin
			c = (i < 3) ? 5'h00 : (i < 7) ? 5'h01 : (i < 11) ? 5'h11 : 5'(2 + $urandom % 15);
			pat = 18'($urandom);
			data = 24'($urandom);
			for (int k = 0; k < 18; k++) data[23-k] = pat[k];
			j = (i == 4) ? 23 : (i == 8) ? 6 : $urandom % 24;
			if (i == 4 || i == 8 || $urandom % 2) data[j] = ~data[j];
			count_in <= c;
			reg_wr(`CAF_OFF_MODE, 16'h0001);
			reg_wr(`CAF_OFF_PAT_LO, pat[15:0]);
			reg_wr(`CAF_OFF_PAT_HI, {14'h0000, pat[17:16]});
			reg_wr(`CAF_OFF_MODE, 16'h0000);
			node_u.send(1'b0, 18'($urandom), data);
			#1 check(accept, data_hit(c, pat, data));
		end
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
